// file: rcs_ctrl.sv
// Reset qualifier, clock gear, oscillator and standby mode controller.
// Assumes osc ticks are one-cycle enables made outside on clk, pins
// arrive asynchronously and are synchronised here.
//
// Overview of operation
// - On reset base clock follows bypass pin; gear resets to divide by 8.
// - After reset execution starts at the shared reset/NMI vector.
// - Reset returns control, mode, saved-mode and read data registers to reset values.
// - Reset makes every port pin a general-purpose input or output.
// - Bypass pin is sampled only during reset, ignored while running.
// - Enabled PLL gives four times the main oscillator frequency.
// - Gear divides base clock by 1, 2, 4 or 8 under software control.
// - Single-clock uses main oscillator; dual-clock adds the sub oscillator.
// - Leaving SLEEP returns to the mode held just before it.
// - Leaving STOP enters the state chosen in control register A.
// - System clock is geared or low-speed per select; ratio per gear field.
// - In SLOW the processor runs from the low-speed sub clock.
// - On low-speed clock the system clock runs from sub ticks; the peripheral clock stops.
// - Gear code 00 is undivided, 01 halves, higher codes divide further.
`timescale 1ns/1ps

module rcs_ctrl #(
  parameter int GEAR_W = 2
) (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic reset_pin_n, // Raw reset pin, active low.
  input wire logic pll_bypass_pin, // Raw pin, high selects PLL.
  input wire logic main_osc_tick, // One pulse per main oscillator cycle.
  input wire logic sub_osc_tick, // One pulse per sub oscillator cycle.
  input wire logic wake_event, // Wake-up request, one-cycle pulse.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic sys_reset_n, // Qualified system reset, active low.
  output logic [31:0] boot_vector, // Reset exception vector.
  output logic port_gpio_force, // Forces ports to general-purpose use.
  output logic base_tick, // Base clock enable pulse.
  output rcs_pkg::rcs_clk_out_t clk_out // Clock enables and oscillators.
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic [1:0] byp_sync_reg;

  // Two flip-flops before any logic reads a pin.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
      byp_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], reset_pin_n};
      byp_sync_reg <= {byp_sync_reg[0], pll_bypass_pin};
    end
  end

  // ----------------------------------------------------------------------
  // Reset qualification
  // ----------------------------------------------------------------------
  logic [3:0] low_cnt_reg, low_cnt_next;
  logic in_reset_reg, in_reset_next;
  logic pll_on_reg, pll_on_next;

  // Count low cycles; accept reset only after the minimum width.
  always_comb begin
    low_cnt_next = low_cnt_reg;
    in_reset_next = in_reset_reg;
    pll_on_next = pll_on_reg;
    if (!rst_sync_reg[1]) begin
      if (low_cnt_reg != rcs_pkg::RESET_MIN_CYC - 4'h1) begin
        low_cnt_next = low_cnt_reg + 4'h1;
      end else begin
        in_reset_next = 1'b1;
      end
    end else begin
      low_cnt_next = 4'h0;
      in_reset_next = 1'b0;
    end
    if (in_reset_reg) begin
      pll_on_next = byp_sync_reg[1];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_reg <= 4'h0;
      in_reset_reg <= 1'b1;
      pll_on_reg <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      in_reset_reg <= in_reset_next;
      pll_on_reg <= pll_on_next;
    end
  end

  logic soft_rst;
  assign soft_rst = in_reset_reg;

  assign sys_reset_n = !in_reset_reg;
  assign port_gpio_force = in_reset_reg;
  assign boot_vector = rcs_pkg::RESET_VECTOR;

  // ----------------------------------------------------------------------
  // Base clock: PLL times four or direct
  // ----------------------------------------------------------------------
  logic [1:0] pll_ph_reg, pll_ph_next;
  logic pll_tick;

  // four enables per main oscillator cycle
  always_comb begin
    pll_ph_next = pll_ph_reg;
    pll_tick = 1'b0;
    if (main_osc_tick) begin
      pll_ph_next = 2'h1;
      pll_tick = 1'b1;
    end else if (pll_ph_reg != 2'h0) begin
      pll_ph_next = pll_ph_reg + 2'h1;
      pll_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_ph_reg <= 2'h0;
    end else begin
      pll_ph_reg <= pll_ph_next;
    end
  end

  assign base_tick = pll_on_reg ? pll_tick : main_osc_tick;

  // ----------------------------------------------------------------------
  // Registers and standby state
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_a_reg, ctrl_a_next;
  logic [7:0] ctrl_b_reg, ctrl_b_next;
  rcs_pkg::rcs_mode_t mode_reg, mode_next;
  rcs_pkg::rcs_mode_t saved_reg, saved_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr, rd, hit;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // Register writes, mode commands and wake handling.
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    mode_next = mode_reg;
    saved_next = saved_reg;
    if (wr && paddr == rcs_pkg::SYS_CTRL_A_OFS) begin
      ctrl_a_next = pwdata[7:0];
    end else if (wr && paddr == rcs_pkg::SYS_CTRL_B_OFS) begin
      // divide select is software's to keep
      ctrl_b_next = pwdata[7:0] & 8'h3b;
    end else if (wr && paddr == rcs_pkg::MODE_CMD_OFS) begin
      case (rcs_pkg::rcs_cmd_t'(pwdata[1:0]))
        rcs_pkg::CMD_SLOW: begin
          mode_next = rcs_pkg::MODE_SLOW;
          ctrl_b_next[rcs_pkg::SYSCLK_SEL_BIT] = 1'b1;
        end
        rcs_pkg::CMD_SLEEP: begin
          saved_next = mode_reg;
          mode_next = rcs_pkg::MODE_SLEEP;
        end
        rcs_pkg::CMD_STOP: begin
          mode_next = rcs_pkg::MODE_STOP;
        end
        default: begin
          mode_next = rcs_pkg::MODE_NORMAL;
          ctrl_b_next[rcs_pkg::SYSCLK_SEL_BIT] = 1'b0;
        end
      endcase
    end
    if (wake_event) begin
      case (mode_reg)
        rcs_pkg::MODE_SLEEP: begin
          mode_next = saved_reg;
        end
        rcs_pkg::MODE_STOP: begin
          ctrl_a_next[rcs_pkg::MAIN_EN_BIT] =
            ctrl_a_reg[rcs_pkg::STOP_MAIN_BIT];
          ctrl_a_next[rcs_pkg::SUB_EN_BIT] = ctrl_a_reg[rcs_pkg::STOP_SUB_BIT];
          ctrl_b_next[rcs_pkg::SYSCLK_SEL_BIT] =
            ctrl_a_reg[rcs_pkg::STOP_CLK_BIT];
          mode_next = ctrl_a_reg[rcs_pkg::STOP_CLK_BIT] ?
            rcs_pkg::MODE_SLOW : rcs_pkg::MODE_NORMAL;
        end
        default: begin
          mode_next = mode_reg;
        end
      endcase
    end
  end

  // Read data is latched in the setup cycle.
  always_comb begin
    hit = 1'b1;
    rdata_next = rdata_reg;
    if (paddr == rcs_pkg::SYS_CTRL_A_OFS) begin
      rdata_next = {24'h0, ctrl_a_reg};
    end else if (paddr == rcs_pkg::SYS_CTRL_B_OFS) begin
      rdata_next = {24'h0, ctrl_b_reg};
    end else if (paddr == rcs_pkg::MODE_CMD_OFS) begin
      rdata_next = 32'h0;
    end else if (paddr == rcs_pkg::STATUS_OFS) begin
      rdata_next = {27'h0, pll_on_reg, mode_reg == rcs_pkg::MODE_SLOW,
        mode_reg};
    end else if (paddr == rcs_pkg::VECTOR_OFS) begin
      rdata_next = rcs_pkg::RESET_VECTOR;
    end else begin
      hit = 1'b0;
      rdata_next = 32'h0;
    end
    if (!rd) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_a_reg <= rcs_pkg::SYS_CTRL_A_RST;
      ctrl_b_reg <= rcs_pkg::SYS_CTRL_B_RST;
      mode_reg <= rcs_pkg::MODE_NORMAL;
      saved_reg <= rcs_pkg::MODE_NORMAL;
      rdata_reg <= 32'h0;
    end else if (soft_rst) begin
      // gear back to divide by eight
      ctrl_a_reg <= rcs_pkg::SYS_CTRL_A_RST;
      ctrl_b_reg <= rcs_pkg::SYS_CTRL_B_RST;
      mode_reg <= rcs_pkg::MODE_NORMAL;
      saved_reg <= rcs_pkg::MODE_NORMAL;
      rdata_reg <= 32'h0;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      mode_reg <= mode_next;
      saved_reg <= saved_next;
      rdata_reg <= rdata_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = psel && penable && !hit;

  // ----------------------------------------------------------------------
  // Gear divider and system clock selection
  // ----------------------------------------------------------------------
  logic [2:0] gear_cnt_reg, gear_cnt_next;
  logic [GEAR_W-1:0] gear_act_reg, gear_act_next;
  logic sel_low_reg, sel_low_next;
  logic gear_tick;
  logic [2:0] gear_max;

  // code 00 undivided, 01 half, 10 quarter, 11 eighth
  // divide by 1, 2, 4 or 8
  assign gear_max = 3'((4'h1 << gear_act_reg) - 4'h1);
  assign gear_tick = base_tick && gear_cnt_reg == gear_max;

  // Ratio and source only change at a period boundary.
  always_comb begin
    gear_cnt_next = gear_cnt_reg;
    gear_act_next = gear_act_reg;
    sel_low_next = sel_low_reg;
    if (base_tick) begin
      gear_cnt_next = gear_tick ? 3'h0 : gear_cnt_reg + 3'h1;
    end
    // switch only on a whole period
    if (gear_tick || (sel_low_reg && sub_osc_tick)) begin
      gear_act_next = ctrl_b_reg[rcs_pkg::GEAR_LSB +: GEAR_W];
      sel_low_next = ctrl_b_reg[rcs_pkg::SYSCLK_SEL_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gear_cnt_reg <= 3'h0;
      gear_act_reg <= GEAR_W'(rcs_pkg::SYS_CTRL_B_RST);
      sel_low_reg <= 1'b0;
    end else begin
      gear_cnt_reg <= gear_cnt_next;
      gear_act_reg <= gear_act_next;
      sel_low_reg <= sel_low_next;
    end
  end

  // low-speed leaves only a few blocks running
  always_comb begin
    clk_out.main_osc_en = ctrl_a_reg[rcs_pkg::MAIN_EN_BIT] &&
      mode_reg != rcs_pkg::MODE_STOP;
    clk_out.sub_osc_en = ctrl_a_reg[rcs_pkg::SUB_EN_BIT] &&
      mode_reg != rcs_pkg::MODE_STOP;
    clk_out.low_speed_only = sel_low_reg || mode_reg == rcs_pkg::MODE_SLEEP;
    clk_out.sys_clk_en = 1'b0;
    if (mode_reg == rcs_pkg::MODE_NORMAL || mode_reg == rcs_pkg::MODE_SLOW) begin
      clk_out.sys_clk_en = sel_low_reg ? sub_osc_tick : gear_tick;
    end
    clk_out.periph_clk_en = clk_out.sys_clk_en && !clk_out.low_speed_only;
  end

endmodule : rcs_ctrl

// file: rcs_ctrl_asserts.sv
// Checker for the reset, clock gear and standby controller.
// Assumes it is bound onto rcs_ctrl and sees only that module's ports.
`timescale 1ns/1ps

module rcs_ctrl_asserts (
  input wire logic clk, // System clock.
  input wire logic resetn, // Reset, active low.
  input wire logic reset_pin_n, // Raw reset pin.
  input wire logic sub_osc_tick, // Sub oscillator pulse.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB address.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pslverr, // APB error.
  input wire logic sys_reset_n, // Qualified reset.
  input wire logic [31:0] boot_vector, // Reset vector.
  input wire logic port_gpio_force, // Port override.
  input wire logic base_tick, // Base clock pulse.
  input wire rcs_pkg::rcs_clk_out_t clk_out // Clock enables.
);
  // --------------------------------------------------------------
  // Helper logic and sequences
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [4:0] lo_cnt_reg;
  logic [4:0] lo_cnt_next;
  logic [4:0] last_lo_reg;

  // Counts raw reset pin low cycles, saturating at the top.
  always_comb begin
    lo_cnt_next = reset_pin_n ? 5'h00 : lo_cnt_reg + {4'h0, ~&lo_cnt_reg};
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lo_cnt_reg <= 5'h00;
    end else begin
      lo_cnt_reg <= lo_cnt_next;
    end
  end

  // Keeps the length of the last finished low pulse, since the
  // qualified reset can fall after the pin has already risen.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_lo_reg <= 5'h00;
    end else if (!reset_pin_n) begin
      last_lo_reg <= 5'h00;
    end else if (lo_cnt_reg != 5'h00) begin
      last_lo_reg <= lo_cnt_reg;
    end
  end

  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  property p_vector; boot_vector == rcs_pkg::RESET_VECTOR; endproperty
  a_vector: assert property (p_vector) else $error("boot vector wrong");
  property p_vec_read;
    s_setup ##0 (!pwrite && paddr == rcs_pkg::VECTOR_OFS) ##1 s_access
      |-> prdata == rcs_pkg::RESET_VECTOR;
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("vector read bad");
  property p_unmapped;
    s_access ##0 (paddr > rcs_pkg::VECTOR_OFS)
      |-> pslverr && (pwrite || prdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access");
  property p_gpio; port_gpio_force == !sys_reset_n; endproperty
  a_gpio: assert property (p_gpio) else $error("port override wrong");
  property p_rst_min;
    $fell(sys_reset_n) |-> lo_cnt_reg >= 5'h0c || last_lo_reg >= 5'h0c;
  endproperty
  a_rst_min: assert property (p_rst_min) else $error("short reset taken");
  property p_rst_rel;
    $rose(sys_reset_n) |-> $past(reset_pin_n) && $past(reset_pin_n, 2);
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("early release");
  property p_slow_src;
    clk_out.low_speed_only && clk_out.sys_clk_en
      |-> sub_osc_tick || $past(sub_osc_tick);
  endproperty
  a_slow_src: assert property (p_slow_src) else $error("slow source");
  property p_fast_src;
    !clk_out.low_speed_only && clk_out.sys_clk_en
      |-> base_tick || $past(base_tick);
  endproperty
  a_fast_src: assert property (p_fast_src) else $error("fast source");
  property p_periph;
    clk_out.low_speed_only |-> !clk_out.periph_clk_en;
  endproperty
  a_periph: assert property (p_periph) else $error("periph clock on");
endmodule : rcs_ctrl_asserts

bind rcs_ctrl rcs_ctrl_asserts rcs_ctrl_asserts_inst (.clk, .resetn,
  .reset_pin_n, .sub_osc_tick, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .sys_reset_n, .boot_vector, .port_gpio_force, .base_tick,
  .clk_out);

// file: rcs_osc_model.sv
// Behavioural oscillators and external reset source for the controller.
// Assumes every oscillator pulse is a one-cycle enable on clk.
`timescale 1ns/1ps

module rcs_osc_model #(
  parameter int MAIN_DIV = 4, // Clock cycles per main oscillator cycle.
  parameter int SUB_DIV = 16 // Clock cycles per sub oscillator cycle.
) (
  input wire logic clk, // System clock.
  input wire logic rst_go, // Starts an external reset pulse.
  input wire logic [4:0] rst_len, // Length of that pulse in cycles.
  output logic main_osc_tick, // One pulse per main oscillator cycle.
  output logic sub_osc_tick, // One pulse per sub oscillator cycle.
  output logic reset_pin_n // Reset pin, active low, idles high.
);
  int main_cnt_reg = 0;
  int sub_cnt_reg = 0;
  logic [4:0] low_cnt_reg = 5'h00;

  // Free-running oscillators; the sub one is the slow partner.
  always @(posedge clk) begin
    main_cnt_reg <= (main_cnt_reg + 1) % MAIN_DIV;
    sub_cnt_reg <= (sub_cnt_reg + 1) % SUB_DIV;
  end
  assign main_osc_tick = (main_cnt_reg == 0);
  assign sub_osc_tick = (sub_cnt_reg == 0);

  // reset low length
  // Holds the pin low for the whole requested count, then lets it go.
  always @(posedge clk) begin
    if (rst_go) begin
      low_cnt_reg <= rst_len;
    end else if (low_cnt_reg != 5'h00) begin
      low_cnt_reg <= low_cnt_reg - 5'h01;
    end
  end
  assign reset_pin_n = (low_cnt_reg == 5'h00);
endmodule : rcs_osc_model

// file: rcs_pkg.sv
// Package for the reset, clock gear and standby controller.
// Assumes a single 125 MHz system clock and an APB register port.
package rcs_pkg;

  // ----------------------------------------------------------------------
  // Register map and field positions
  // ----------------------------------------------------------------------
  localparam logic [11:0] SYS_CTRL_A_OFS = 12'h000;
  localparam logic [11:0] SYS_CTRL_B_OFS = 12'h004;
  localparam logic [11:0] MODE_CMD_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;
  localparam logic [11:0] VECTOR_OFS = 12'h010;

  // Control register A fields: oscillator enables and post-stop choices.
  localparam int MAIN_EN_BIT = 7;
  localparam int SUB_EN_BIT = 6;
  localparam int STOP_MAIN_BIT = 5;
  localparam int STOP_SUB_BIT = 4;
  localparam int STOP_CLK_BIT = 3;
  // Control register B fields.
  localparam int SYSCLK_SEL_BIT = 5;
  localparam int DIV_SEL_BIT = 3;
  localparam int GEAR_LSB = 0;

  localparam logic [7:0] SYS_CTRL_A_RST = 8'ha0;
  localparam logic [7:0] SYS_CTRL_B_RST = 8'h03;

  // Reset vector shared with the non-maskable interrupt.
  localparam logic [31:0] RESET_VECTOR = 32'hbfc0_0000;
  localparam logic [2:0] PLL_MULT = 3'h4;
  // Reset pin must be low at least this many system clock cycles.
  localparam logic [3:0] RESET_MIN_CYC = 4'hc;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_SLOW = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_STOP = 3'b011
  } rcs_mode_t;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_SLOW = 2'b01,
    CMD_SLEEP = 2'b10,
    CMD_STOP = 2'b11
  } rcs_cmd_t;

  typedef struct packed {
    logic sys_clk_en;
    logic periph_clk_en;
    logic low_speed_only;
    logic main_osc_en;
    logic sub_osc_en;
  } rcs_clk_out_t;

endpackage : rcs_pkg

// file: testbench.sv
// Self-checking bench for the reset, clock gear and standby controller.
// Assumes the oscillator model drives ticks and the reset pin.
`timescale 1ns/1ps

module testbench;
  logic clk = 1'b0, resetn = 1'b0, pll_bypass_pin = 1'b1;
  logic wake_event = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [4:0] rst_len = 5'h00;
  logic rst_go = 1'b0;
  logic reset_pin_n, main_osc_tick, sub_osc_tick, pready, pslverr;
  logic sys_reset_n, port_gpio_force, base_tick;
  logic [31:0] prdata, boot_vector;
  rcs_pkg::rcs_clk_out_t clk_out;
  logic [15:0] lfsr = 16'h8228;
  logic [32:0] exp_q[$], msk_q[$];
  int n_fail = 0, checks = 0, nb, ns, nm;
  int n_low = 0;

  always #4 clk = ~clk;

  rcs_osc_model rcs_osc_model_inst (.clk, .rst_go, .rst_len,
    .main_osc_tick, .sub_osc_tick, .reset_pin_n);
  rcs_ctrl rcs_ctrl_inst (.clk, .resetn, .reset_pin_n, .pll_bypass_pin,
    .main_osc_tick, .sub_osc_tick, .wake_event, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sys_reset_n,
    .boot_vector, .port_gpio_force, .base_tick, .clk_out);

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [32:0] e, s);
    checks++;
    if (e !== s) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  // Next value of the bench's random source.
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  // One APB transfer; a read notes its expected value and mask first.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e, m);
    if (!wr) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // One-cycle pulse on the reset request or on the wake-up input.
  task automatic pulse(input bit rst);
    if (rst) rst_go <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge clk);
    rst_go <= 1'b0;
    wake_event <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : pulse

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Compares every read as it completes against the oldest note.
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite)
      chk("read", exp_q.pop_front(), {pslverr, prdata} & msk_q.pop_front());
  end

  // Counts cycles spent in qualified reset.
  always @(posedge clk) begin
    if (!sys_reset_n) n_low <= n_low + 1;
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    apb(0, rcs_pkg::SYS_CTRL_A_OFS, 0, 33'h0a0, '1);
    apb(0, rcs_pkg::SYS_CTRL_B_OFS, 0, 33'h003, '1);
    apb(0, rcs_pkg::VECTOR_OFS, 0, 33'h0bfc0_0000, '1);
    pll_bypass_pin <= 1'b0;
    apb(0, rcs_pkg::STATUS_OFS, 0, 33'h010, 33'h010);
    apb(1, 12'h020, {lfsr, lfsr}, 0, 0);
    apb(0, 12'h020, 0, 33'h1_0000_0000, '1);
    $display("reset values and map done");
    // every gear code runs here, so code 00 reaches the full clock.
    for (int g = 0; g < 4; g++) begin
      lfsr = lfsr_next(lfsr);
      apb(1, rcs_pkg::SYS_CTRL_B_OFS,
        ({lfsr, lfsr} & 32'hffff_ffc4) | g, 0, 0);
      apb(0, rcs_pkg::SYS_CTRL_B_OFS, 0, 33'(g), '1);
      repeat (64) @(posedge clk);
      {nb, ns, nm} = '0;
      repeat (256) begin
        @(posedge clk);
        nb += base_tick;
        ns += clk_out.sys_clk_en;
        nm += main_osc_tick;
      end
      chk("gear ratio", 1, (ns * (1 << g) - nb) inside {[-8:8]});
      chk("pll ratio", 1, (nm * 4 - nb) inside {[-8:8]});
    end
    $display("gear ratios done");
    apb(1, rcs_pkg::SYS_CTRL_A_OFS, 32'h0000_00e0, 0, 0);
    repeat (64) @(posedge clk);
    for (int c = 1; c < 4; c++) begin
      apb(1, rcs_pkg::MODE_CMD_OFS, c, 0, 0);
      apb(0, rcs_pkg::STATUS_OFS, 0, 33'(c), 33'h007);
      if (c == 3) begin
        chk("oscs off in stop", 0,
          {clk_out.main_osc_en, clk_out.sub_osc_en});
      end
      if (c == 2) begin
        pulse(0);
        apb(0, rcs_pkg::STATUS_OFS, 0, 33'h001, 33'h007);
        apb(1, rcs_pkg::MODE_CMD_OFS, 0, 0, 0);
        apb(0, rcs_pkg::STATUS_OFS, 0, 33'h000, 33'h007);
        apb(1, rcs_pkg::SYS_CTRL_A_OFS, 32'h0000_0098, 0, 0);
      end
    end
    pulse(0);
    chk("oscs after stop", 1,
      {clk_out.main_osc_en, clk_out.sub_osc_en});
    apb(0, rcs_pkg::SYS_CTRL_B_OFS, 0, 33'h020, 33'h020);
    $display("standby modes done");
    rst_len <= 5'h06;
    nb = n_low;
    pulse(1);
    chk("sys_reset_n", 1, sys_reset_n);
    chk("short reset ignored", 33'(nb), 33'(n_low));
    rst_len <= 5'h0c;
    pulse(1);
    chk("long reset taken", 1, 33'(n_low > nb));
    apb(0, rcs_pkg::SYS_CTRL_B_OFS, 0, 33'h003, '1);
    apb(0, rcs_pkg::SYS_CTRL_A_OFS, 0, 33'h0a0, '1);
    apb(0, rcs_pkg::STATUS_OFS, 0, 33'h000, 33'h010);
    $display("reset pin done");
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule : testbench
